// File: common/sapc_pkg.sv
package sapc_pkg;
  // ---------------------------------------------------------------
  // timing constants
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 880;
  localparam int ACQ_MIN_NS = 120;
  localparam int HS_GAP_NS = 140;
  localparam int PS_WAKE_NS = 1000;
  localparam int PS_SETTLE_NS = 20000;
  localparam int FS_WAKE_NS = 500000;
  // least times round up
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HS_GAP_CYC = (HS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PS_WAKE_CYC = (PS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PS_SETTLE_CYC =
    (PS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FS_WAKE_CYC = (FS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int CNT_W = 20;
  localparam logic [11:0] RESULT_RST = 12'h000;
  // device power states
  typedef enum logic [2:0] {
    SAPC_ACQ = 3'b000,
    SAPC_CONV = 3'b001,
    SAPC_SLEEP = 3'b010,
    SAPC_WAKE = 3'b011
  } sapc_state_e;
  // host states
  typedef enum logic [2:0] {
    SAPC_H_IDLE = 3'b000,
    SAPC_H_CONV = 3'b001,
    SAPC_H_READ = 3'b010,
    SAPC_H_GAP = 3'b011,
    SAPC_H_WAKE = 3'b100
  } sapc_hstate_e;
endpackage

// File: common/sapc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sapc_if;
  logic start_conversion_n;
  logic sleep_depth_select;
  logic cs_n;
  logic rd_n;
  logic busy;
  logic [11:0] result_bus_out;
  logic result_bus_oe;
  logic [11:0] result_bus;
  // bus level resolved from the device enable; undriven reads as zero
  assign result_bus = result_bus_oe ? result_bus_out : 12'h000;
  modport dev (
    input start_conversion_n, sleep_depth_select, cs_n, rd_n,
    output busy, result_bus_out, result_bus_oe
  );
  modport host (
    output start_conversion_n, sleep_depth_select, cs_n, rd_n,
    input busy, result_bus
  );
endinterface
`default_nettype wire

// File: verilog/sapc_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_dev #(
  parameter int FS_WAKE_CYCLES = sapc_pkg::FS_WAKE_CYC,
  parameter int PS_WAKE_CYCLES = sapc_pkg::PS_WAKE_CYC
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // link
  sapc_if.dev link,
  // converter core side
  input wire logic [11:0] sample_code_in,
  output logic osc_run_out,
  output logic comparator_on_out,
  output logic reference_on_out,
  output logic ref_buffer_full_out,
  output logic track_out,
  output logic acq_ok_out
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic conv_n_d_r;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r <= 4'hF;
      sync_r <= 4'hF;
      conv_n_d_r <= 1'b1;
    end
    else if (clk_en_in)
    begin
      meta_r <= {link.start_conversion_n, link.sleep_depth_select,
                 link.cs_n, link.rd_n};
      sync_r <= meta_r;
      conv_n_d_r <= sync_r[3];
    end
  end
  wire conv_n_s = sync_r[3];
  wire depth_s = sync_r[2];
  wire cs_n_s = sync_r[1];
  wire rd_n_s = sync_r[0];
  wire conv_fall = conv_n_d_r & ~conv_n_s;
  wire conv_rise = ~conv_n_d_r & conv_n_s;
  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  sapc_pkg::sapc_state_e state_r, state_nxt;
  logic [sapc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt;
  logic partial_r, partial_nxt;
  logic [11:0] result_r, result_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] acq_cnt_r;
  wire conv_done = (state_r == sapc_pkg::SAPC_CONV) &&
                   (cnt_r == sapc_pkg::CONV_CYC[sapc_pkg::CNT_W-1:0] - 1'b1);
  wire wake_done = (state_r == sapc_pkg::SAPC_WAKE) &&
                   (cnt_r == {sapc_pkg::CNT_W{1'b0}});
  // next-state decode
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    partial_nxt = partial_r;
    result_nxt = result_r;
    busy_nxt = busy_r;
    case (state_r)
      sapc_pkg::SAPC_ACQ:
      begin
        if (conv_fall)
        begin
          state_nxt = sapc_pkg::SAPC_CONV;
          cnt_nxt = '0;
          busy_nxt = 1'b1;
        end
      end
      sapc_pkg::SAPC_CONV:
      begin
        if (conv_fall)
          cnt_nxt = '0;
        else if (conv_done)
        begin
          result_nxt = sample_code_in;
          busy_nxt = 1'b0;
          if (conv_n_s)
            state_nxt = sapc_pkg::SAPC_ACQ;
          else
          begin
            state_nxt = sapc_pkg::SAPC_SLEEP;
            partial_nxt = depth_s;
          end
        end
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      sapc_pkg::SAPC_SLEEP:
      begin
        // depth select is not looked at here
        if (conv_rise)
        begin
          state_nxt = sapc_pkg::SAPC_WAKE;
          pend_nxt = 1'b0;
          cnt_nxt = partial_r ? PS_WAKE_CYCLES[sapc_pkg::CNT_W-1:0]
                              : FS_WAKE_CYCLES[sapc_pkg::CNT_W-1:0];
        end
      end
      sapc_pkg::SAPC_WAKE:
      begin
        if (conv_fall)
          pend_nxt = 1'b1;
        else if (conv_rise)
          pend_nxt = 1'b0;
        if (wake_done)
        begin
          pend_nxt = 1'b0;
          if (pend_r || conv_fall)
          begin
            state_nxt = sapc_pkg::SAPC_CONV;
            cnt_nxt = '0;
            busy_nxt = 1'b1;
          end
          else
            state_nxt = sapc_pkg::SAPC_ACQ;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      default:
      begin
        state_nxt = sapc_pkg::SAPC_ACQ;
        busy_nxt = 1'b0;
      end
    endcase
  end
  // state registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= sapc_pkg::SAPC_ACQ;
      cnt_r <= '0;
      pend_r <= 1'b0;
      partial_r <= 1'b0;
      result_r <= sapc_pkg::RESULT_RST;
      busy_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      partial_r <= partial_nxt;
      result_r <= result_nxt;
      busy_r <= busy_nxt;
    end
  end
  // ---------------------------------------------------------------
  // acquisition timer and output drive
  // ---------------------------------------------------------------
  wire acq_full = (acq_cnt_r >= sapc_pkg::ACQ_MIN_CYC[7:0]);
  wire bus_en = ~cs_n_s & ~rd_n_s;
  wire asleep = (state_r == sapc_pkg::SAPC_SLEEP);
  wire in_conv = (state_nxt == sapc_pkg::SAPC_CONV);
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      acq_cnt_r <= 8'h00;
      link.busy <= 1'b0;
      link.result_bus_out <= sapc_pkg::RESULT_RST;
      link.result_bus_oe <= 1'b0;
      osc_run_out <= 1'b1;
      comparator_on_out <= 1'b1;
      reference_on_out <= 1'b1;
      ref_buffer_full_out <= 1'b1;
      track_out <= 1'b1;
      acq_ok_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (state_r == sapc_pkg::SAPC_ACQ && !acq_full)
        acq_cnt_r <= acq_cnt_r + 8'h01;
      else if (state_r != sapc_pkg::SAPC_ACQ)
        acq_cnt_r <= 8'h00;
      link.busy <= busy_nxt;
      link.result_bus_out <= result_nxt;
      link.result_bus_oe <= bus_en;
      osc_run_out <= ~(state_nxt == sapc_pkg::SAPC_SLEEP);
      comparator_on_out <= ~(state_nxt == sapc_pkg::SAPC_SLEEP);
      reference_on_out <= ~(state_nxt == sapc_pkg::SAPC_SLEEP &&
                            !partial_nxt);
      ref_buffer_full_out <= ~(state_nxt == sapc_pkg::SAPC_SLEEP);
      track_out <= ~in_conv & ~asleep;
      acq_ok_out <= acq_full && (state_r == sapc_pkg::SAPC_ACQ);
    end
  end
endmodule
`default_nettype wire

// File: verilog/sapc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_host #(
  parameter int SETTLE_CYCLES = sapc_pkg::PS_SETTLE_CYC
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // link
  sapc_if.host link,
  // user side
  input wire logic go_in,
  input wire logic sleep_after_in,
  input wire logic partial_in,
  output logic [11:0] data_out,
  output logic data_valid_out,
  output logic idle_out
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [12:0] meta_r;
  logic [12:0] sync_r;
  logic busy_d_r;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      busy_d_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      meta_r <= {link.busy, link.result_bus};
      sync_r <= meta_r;
      busy_d_r <= sync_r[12];
    end
  end
  wire busy_s = sync_r[12];
  wire busy_fall = busy_d_r & ~busy_s;
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  sapc_pkg::sapc_hstate_e st_r;
  logic [sapc_pkg::CNT_W-1:0] cnt_r;
  logic asleep_r;
  logic dummy_r;
  wire gap_done = (cnt_r == {sapc_pkg::CNT_W{1'b0}});
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= sapc_pkg::SAPC_H_IDLE;
      cnt_r <= '0;
      asleep_r <= 1'b0;
      dummy_r <= 1'b1;
      link.start_conversion_n <= 1'b1;
      link.sleep_depth_select <= 1'b1;
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      data_out <= sapc_pkg::RESULT_RST;
      data_valid_out <= 1'b0;
      idle_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      data_valid_out <= 1'b0;
      case (st_r)
        sapc_pkg::SAPC_H_IDLE:
        begin
          if (go_in || dummy_r)
          begin
            idle_out <= 1'b0;
            link.sleep_depth_select <= partial_in;
            if (asleep_r)
            begin
              link.start_conversion_n <= 1'b1; // rising edge wakes
              cnt_r <= SETTLE_CYCLES[sapc_pkg::CNT_W-1:0];
              st_r <= sapc_pkg::SAPC_H_WAKE;
            end
            else
            begin
              link.start_conversion_n <= 1'b0;
              cnt_r <= '0;
              st_r <= sapc_pkg::SAPC_H_CONV;
            end
          end
        end
        sapc_pkg::SAPC_H_WAKE:
        begin
          if (gap_done)
          begin
            asleep_r <= 1'b0;
            link.start_conversion_n <= 1'b0;
            st_r <= sapc_pkg::SAPC_H_CONV;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        sapc_pkg::SAPC_H_CONV:
        begin
          // bus untouched while busy
          if (cnt_r < 20'h00004)
            cnt_r <= cnt_r + 1'b1;
          else if (busy_s && !sleep_after_in)
            link.start_conversion_n <= 1'b1; // high before end selects fast
          if (busy_fall)
          begin
            asleep_r <= ~link.start_conversion_n;
            link.cs_n <= 1'b0;
            link.rd_n <= 1'b0;
            // three cycles to bus enable plus two of sync before sampling
            cnt_r <= 20'h00006;
            st_r <= sapc_pkg::SAPC_H_READ;
          end
        end
        sapc_pkg::SAPC_H_READ:
        begin
          if (gap_done)
          begin
            link.cs_n <= 1'b1;
            link.rd_n <= 1'b1;
            data_out <= sync_r[11:0];
            data_valid_out <= ~dummy_r;
            dummy_r <= 1'b0;
            cnt_r <= sapc_pkg::HS_GAP_CYC[sapc_pkg::CNT_W-1:0];
            st_r <= sapc_pkg::SAPC_H_GAP;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        sapc_pkg::SAPC_H_GAP:
        begin
          if (gap_done)
          begin
            idle_out <= 1'b1;
            st_r <= sapc_pkg::SAPC_H_IDLE;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        end
        default:
          st_r <= sapc_pkg::SAPC_H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test/sapc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link signals
  input wire logic start_conversion_n,
  input wire logic sleep_depth_select,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic busy,
  input wire logic [11:0] result_bus_out,
  input wire logic result_bus_oe
);
  logic [7:0] len_r;
  logic [7:0] gap_r;
  logic start_q_r;
  logic pend_r;
  logic restart_r;
  logic fast_r;
  logic start_fell;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------
  // helper state: busy length, gap, pending start, mode
  // ----------------------------------------------------------
  assign start_fell = start_q_r & ~start_conversion_n;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      len_r <= 8'h00;
      gap_r <= 8'hFF;
      start_q_r <= 1'b1;
      pend_r <= 1'b0;
      restart_r <= 1'b0;
      fast_r <= 1'b0;
    end
    else
    begin
      len_r <= busy ? len_r + 8'h01 : 8'h00;
      gap_r <= busy ? 8'h00 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h01);
      start_q_r <= start_conversion_n;
      pend_r <= start_fell | (pend_r & ~busy);
      restart_r <= busy & (restart_r | start_fell);
      if ($fell(busy))
        fast_r <= start_conversion_n;
    end
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  chk_oe_when_read: assert property (
    (!cs_n && !rd_n)[*5] |-> result_bus_oe)
    else $error("bus not driven during read");
  chk_oe_released: assert property (
    (cs_n || rd_n)[*5] |-> !result_bus_oe)
    else $error("bus still driven after read end");
  chk_busy_on_start: assert property (
    fast_r && !busy && start_fell |-> ##[2:6] busy)
    else $error("busy did not follow start edge");
  chk_busy_length: assert property (
    $fell(busy) && !restart_r |-> len_r == sapc_pkg::CONV_CYC)
    else $error("conversion length wrong");
  chk_result_hold: assert property (
    $changed(result_bus_out) |-> $fell(busy))
    else $error("result changed outside conversion end");
  chk_no_busy_read: assert property (
    busy |-> (cs_n || rd_n))
    else $error("read during conversion");
  chk_start_gap: assert property (
    start_fell |-> gap_r >= 8'h0E)
    else $error("start too soon after conversion");
  chk_wake_quiet: assert property (
    !busy && $rose(start_conversion_n) |=> (!busy)[*5])
    else $error("busy rose on wake alone");
  chk_busy_cause: assert property (
    $rose(busy) |-> pend_r)
    else $error("busy rose without start edge");
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic go_in = 1'b0;
  logic sleep_after_in = 1'b0;
  logic partial_in = 1'b1;
  logic [11:0] code_r = 12'h000;
  logic [11:0] data_out;
  logic data_valid_out;
  logic idle_out;
  logic osc_a;
  logic ref_a;
  logic cmp_a;
  logic buf_a;
  logic track_b;
  logic acq_b;
  logic en_a = 1'b1;
  logic en_b = 1'b1;
  int bad_count = 0;
  int check_count = 0;
  int cyc_count = 0;
  sapc_if link_a();
  sapc_if link_b();
  // ----------------------------------------------------------
  // design ends, second device faced by the bench
  // ----------------------------------------------------------
  sapc_dev #(.FS_WAKE_CYCLES(200), .PS_WAKE_CYCLES(20)) u_sapc_dev (
    .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(en_a), .link(link_a),
    .sample_code_in(code_r), .osc_run_out(osc_a), .comparator_on_out(cmp_a),
    .reference_on_out(ref_a), .ref_buffer_full_out(buf_a), .track_out(),
    .acq_ok_out());
  sapc_dev #(.FS_WAKE_CYCLES(200), .PS_WAKE_CYCLES(20)) u_sapc_dev_b (
    .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(en_b), .link(link_b),
    .sample_code_in(code_r), .osc_run_out(), .comparator_on_out(),
    .reference_on_out(), .ref_buffer_full_out(), .track_out(track_b),
    .acq_ok_out(acq_b));
  sapc_host #(.SETTLE_CYCLES(50)) u_sapc_host (
    .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(en_a), .link(link_a),
    .go_in(go_in), .sleep_after_in(sleep_after_in),
    .partial_in(partial_in), .data_out(data_out),
    .data_valid_out(data_valid_out), .idle_out(idle_out));
  sapc_monitor u_sapc_monitor (
    .clk_in(clk_in), .rst_in(rst_in),
    .start_conversion_n(link_a.start_conversion_n),
    .sleep_depth_select(link_a.sleep_depth_select),
    .cs_n(link_a.cs_n), .rd_n(link_a.rd_n), .busy(link_a.busy),
    .result_bus_out(link_a.result_bus_out),
    .result_bus_oe(link_a.result_bus_oe));
  // clock and hang guard
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc_count++;
    if (cyc_count == 12000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic check(input string name, input logic [11:0] seen, exp);
    check_count++;
    if (seen !== exp)
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    if (seen !== exp)
      bad_count++;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // one host request, judged on the returned word
  task automatic host_conv(input logic [11:0] code, input logic slp, prt);
    int n;
    n = 0;
    while (idle_out !== 1'b1 && n < 3000)
    begin
      cycles(1);
      n++;
    end
    @(posedge clk_in);
    code_r <= code;
    sleep_after_in <= slp;
    partial_in <= prt;
    go_in <= 1'b1;
    @(posedge clk_in);
    go_in <= 1'b0;
    n = 0;
    while (data_valid_out !== 1'b1 && n < 3000)
    begin
      cycles(1);
      n++;
    end
    check("data_out", data_out, code);
  endtask
  task automatic set_b(input logic st, cs, rd);
    @(posedge clk_in);
    link_b.start_conversion_n <= st;
    link_b.cs_n <= cs;
    link_b.rd_n <= rd;
  endtask
  task automatic wait_busy_b(input logic v);
    int n;
    n = 0;
    while (link_b.busy !== v && n < 300)
    begin
      cycles(1);
      n++;
    end
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_fast;
    host_conv(12'hA5C, 1'b0, 1'b1);
    host_conv(12'hFFF, 1'b0, 1'b1);
    host_conv(12'h000, 1'b0, 1'b1);
    cycles(20);
    check("idle bus", link_a.result_bus, 12'h000);
    $display("test fast done");
  endtask
  task automatic t_sleep;
    for (int p = 1; p >= 0; p--)
    begin
      host_conv(12'h001, 1'b1, p[0]);
      cycles(10);
      check("osc", {11'h000, osc_a}, 12'h000);
      check("comparator", {11'h000, cmp_a}, 12'h000);
      check("ref buffer", {11'h000, buf_a}, 12'h000);
      check("reference", {11'h000, ref_a}, {11'h000, p[0]});
      host_conv(12'h800, 1'b0, p[0]);
    end
    $display("test sleep done");
  endtask
  task automatic t_restart;
    set_b(1'b0, 1'b1, 1'b1);
    cycles(20);
    set_b(1'b1, 1'b1, 1'b1);
    set_b(1'b0, 1'b1, 1'b1);
    set_b(1'b1, 1'b1, 1'b1);
    cycles(70);
    check("busy held", {11'h000, link_b.busy}, 12'h001);
    wait_busy_b(1'b0);
    check("busy end", {11'h000, link_b.busy}, 12'h000);
    cycles(20);
    check("tracking", {11'h000, track_b}, 12'h001);
    check("acq ok", {11'h000, acq_b}, 12'h001);
    $display("test restart done");
  endtask
  task automatic t_freeze;
    set_b(1'b0, 1'b1, 1'b1);
    wait_busy_b(1'b1);
    @(posedge clk_in);
    en_b <= 1'b0;
    cycles(100);
    check("frozen busy", {11'h000, link_b.busy}, 12'h001);
    @(posedge clk_in);
    en_b <= 1'b1;
    set_b(1'b1, 1'b1, 1'b1);
    wait_busy_b(1'b0);
    check("thawed end", {11'h000, link_b.busy}, 12'h000);
    cycles(20);
    $display("test freeze done");
  endtask
  task automatic t_read;
    @(posedge clk_in);
    code_r <= 12'h5A3;
    set_b(1'b0, 1'b0, 1'b0);
    set_b(1'b1, 1'b0, 1'b0);
    wait_busy_b(1'b1);
    wait_busy_b(1'b0);
    check("held read", link_b.result_bus, 12'h5A3);
    @(posedge clk_in);
    code_r <= 12'h0F0;
    set_b(1'b1, 1'b0, 1'b1);
    cycles(6);
    check("rd high", link_b.result_bus, 12'h000);
    set_b(1'b1, 1'b1, 1'b0);
    cycles(6);
    check("cs high", link_b.result_bus, 12'h000);
    set_b(1'b1, 1'b0, 1'b0);
    cycles(6);
    check("reread", link_b.result_bus, 12'h5A3);
    set_b(1'b1, 1'b1, 1'b1);
    cycles(20);
    $display("test read done");
  endtask
  task automatic t_wake;
    @(posedge clk_in);
    link_b.sleep_depth_select <= 1'b1;
    set_b(1'b0, 1'b1, 1'b1);
    wait_busy_b(1'b1);
    wait_busy_b(1'b0);
    cycles(10);
    @(posedge clk_in);
    link_b.sleep_depth_select <= 1'b0;
    cycles(10);
    set_b(1'b1, 1'b1, 1'b1);
    cycles(2);
    set_b(1'b0, 1'b1, 1'b1);
    cycles(8);
    check("deferred", {11'h000, link_b.busy}, 12'h000);
    cycles(40);
    check("partial wake", {11'h000, link_b.busy}, 12'h001);
    set_b(1'b1, 1'b1, 1'b1);
    wait_busy_b(1'b0);
    $display("test wake done");
  endtask
  // main sequence
  initial
  begin
    link_b.start_conversion_n = 1'b1;
    link_b.sleep_depth_select = 1'b1;
    link_b.cs_n = 1'b1;
    link_b.rd_n = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    cycles(4);
    t_fast();
    t_sleep();
    t_restart();
    t_freeze();
    t_read();
    t_wake();
    stop_test();
  end
endmodule
`default_nettype wire
